// ==== rtl/hps_device.sv ====
// module: device end of the separate-bus host port
`timescale 1ns/1ps
module hps_device (
  input  wire logic   clk,
  input  wire logic   rst,
  hps_if.device       pins,
  output hps_pkg::hps_data_t core_rd_data,
  input  wire hps_pkg::hps_addr_t core_rd_addr,
  output logic        core_wr_pulse,
  output hps_pkg::hps_addr_t core_wr_addr,
  output logic        layout_error
);
  import hps_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} hps_dstate_t;

  // two-stage synchronisers: sel, wr, rd, ds, dir, layout, style
  localparam int unsigned NSYNC = 7;
  // idle pin levels: strobes and select high, separate-bus layout
  localparam logic [NSYNC-1:0] SYNC_IDLE = 7'h0F;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  // address and data ride the same two stages as the strobes
  hps_addr_t        a1_q;
  hps_addr_t        a2_q;
  hps_data_t        d1_q;
  hps_data_t        d2_q;
  assign raw = {pins.strobe_style_select, pins.bus_layout_select,
                pins.host_direction, pins.host_data_strobe_n,
                pins.host_read_strobe_n, pins.host_write_strobe_n,
                pins.host_select_n};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
      a1_q <= '0;
      a2_q <= '0;
      d1_q <= REG_RESET;
      d2_q <= REG_RESET;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      a1_q <= pins.host_reg_address;
      a2_q <= a1_q;
      d1_q <= pins.data_bus;
      d2_q <= d1_q;
    end
  end

  logic sel_n;
  logic wr_n;
  logic rd_n;
  logic ds_n;
  logic dir;
  logic layout;
  logic style;
  assign {style, layout, dir, ds_n, rd_n, wr_n, sel_n} = s2_q;

  // start and still-active terms per strobe style
  logic start_wr;
  logic start_rd;
  logic still_wr;
  logic still_rd;
  always_comb begin
    if (!style) begin
      start_wr = !wr_n && !sel_n;
      start_rd = !rd_n && !sel_n && wr_n;
      still_wr = !wr_n && !sel_n;
      still_rd = !rd_n && !sel_n;
    end else begin
      start_wr = !ds_n && !sel_n && !dir;
      start_rd = !ds_n && !sel_n && dir;
      still_wr = !ds_n && !sel_n;
      still_rd = !ds_n && !sel_n;
    end
  end

  hps_dstate_t st_q, st_d;
  hps_addr_t   addr_q, addr_d;
  hps_data_t   wdata_q, wdata_d;
  logic        ack_n_q, ack_n_d;
  logic        oe_n_q, oe_n_d;
  hps_data_t   dout_q, dout_d;
  logic        wp_q, wp_d;
  hps_addr_t   wa_q, wa_d;
  logic        lerr_q, lerr_d;
  hps_data_t   regs_q [NUM_REGS];
  hps_data_t   crd_q, crd_d;

  // access sequencer: idle, read, write
  always_comb begin
    st_d    = st_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    ack_n_d = ack_n_q;
    oe_n_d  = oe_n_q;
    dout_d  = dout_q;
    wp_d    = 1'b0;
    wa_d    = wa_q;
    lerr_d  = layout;
    crd_d   = regs_q[core_rd_addr];
    unique case (st_q)
      ST_IDLE: begin
        if (!layout && start_wr) begin
          st_d    = ST_WRITE;
          addr_d  = a2_q;
          ack_n_d = 1'b0;
        end else if (!layout && start_rd) begin
          st_d    = ST_READ;
          addr_d  = a2_q;
          ack_n_d = 1'b0;
          oe_n_d  = 1'b0;
          dout_d  = regs_q[a2_q];
        end
      end
      ST_READ: begin
        dout_d = regs_q[addr_q];
        if (!still_rd) begin
          st_d    = ST_IDLE;
          ack_n_d = 1'b1;
          oe_n_d  = 1'b1;
        end
      end
      ST_WRITE: begin
        wdata_d = d2_q;
        if (!still_wr) begin
          st_d    = ST_IDLE;
          ack_n_d = 1'b1;
          wp_d    = 1'b1;
          wa_d    = addr_q;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q    <= ST_IDLE;
      addr_q  <= '0;
      wdata_q <= REG_RESET;
      ack_n_q <= 1'b1;
      oe_n_q  <= 1'b1;
      dout_q  <= REG_RESET;
      wp_q    <= 1'b0;
      wa_q    <= '0;
      lerr_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      ack_n_q <= ack_n_d;
      oe_n_q  <= oe_n_d;
      dout_q  <= dout_d;
      wp_q    <= wp_d;
      wa_q    <= wa_d;
      lerr_q  <= lerr_d;
    end
  end

  // register file: write lands with the last sampled data
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      hps_data_t nxt;
      assign nxt = (wp_d && addr_q == ADDR_W'(gi)) ? wdata_q : regs_q[gi];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          regs_q[gi] <= REG_RESET;
        end else begin
          regs_q[gi] <= nxt;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crd_q <= REG_RESET;
    end else begin
      crd_q <= crd_d;
    end
  end

  // every pin and core output comes from a flop
  assign pins.port_acknowledge_n = ack_n_q;
  assign pins.dev_data_oe_n      = oe_n_q;
  assign pins.dev_data_o         = dout_q;
  assign core_rd_data  = crd_q;
  assign core_wr_pulse = wp_q;
  assign core_wr_addr  = wa_q;
  assign layout_error  = lerr_q;
endmodule // hps_device

// ==== rtl/hps_host.sv ====
// module: host end of the separate-bus host port
`timescale 1ns/1ps
module hps_host (
  input  wire logic   clk,
  input  wire logic   rst,
  hps_if.host         pins,
  input  wire logic   style_sel,
  input  wire logic   req_valid,
  input  wire logic   req_write,
  input  wire hps_pkg::hps_addr_t req_addr,
  input  wire hps_pkg::hps_data_t req_wdata,
  output logic        req_ready,
  output logic        rsp_valid,
  output hps_pkg::hps_data_t rsp_rdata
);
  import hps_pkg::*;

  typedef enum logic [2:0] {
    HS_IDLE, HS_SETUP, HS_WAIT_ACK, HS_PULSE, HS_HOLD
  } hps_hstate_t;

  // acknowledge and data come from the other end: two flops each
  logic      ack1_q, ack2_q;
  hps_data_t d1_q, d2_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack1_q <= 1'b1;
      ack2_q <= 1'b1;
      d1_q   <= '0;
      d2_q   <= '0;
    end else begin
      ack1_q <= pins.port_acknowledge_n;
      ack2_q <= ack1_q;
      d1_q   <= pins.data_bus;
      d2_q   <= d1_q;
    end
  end

  hps_hstate_t      st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             wr_q, wr_d;
  logic             style_q, style_d;
  hps_addr_t        a_q, a_d;
  hps_data_t        wd_q, wd_d;
  logic             strobe_q, strobe_d;
  logic             rdy_q, rdy_d;
  logic             rv_q, rv_d;
  hps_data_t        rd_q, rd_d;
  // pin levels registered so strobes and select cannot glitch
  logic             sel_n_q, sel_n_d;
  logic             wrs_n_q, wrs_n_d;
  logic             rds_n_q, rds_n_d;
  logic             dss_n_q, dss_n_d;
  logic             dir_q, dir_d;
  logic             hoe_n_q, hoe_n_d;

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    wr_d     = wr_q;
    style_d  = style_q;
    a_d      = a_q;
    wd_d     = wd_q;
    strobe_d = strobe_q;
    rdy_d    = rdy_q;
    rv_d     = 1'b0;
    rd_d     = rd_q;
    unique case (st_q)
      HS_IDLE: begin
        rdy_d = 1'b1;
        if (req_valid && rdy_q) begin
          st_d    = HS_SETUP;
          rdy_d   = 1'b0;
          wr_d    = req_write;
          a_d     = req_addr;
          wd_d    = req_wdata;
          style_d = style_sel;
          cnt_d   = CNT_W'(SETUP_CYC);
        end
      end
      HS_SETUP: begin // address and direction settle first
        if (cnt_q <= 1) begin
          st_d     = HS_WAIT_ACK;
          strobe_d = 1'b1;
          cnt_d    = CNT_W'(PULSE_CYC);
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      HS_WAIT_ACK: begin // minimum pulse width, then acknowledge
        if (cnt_q > 1) begin
          cnt_d = cnt_q - 1'b1;
        end
        if (!ack2_q && cnt_q <= 1) begin
          st_d = HS_PULSE;
        end
      end
      HS_PULSE: begin
        if (!wr_q) begin
          rd_d = d2_q;
        end
        st_d     = HS_HOLD;
        strobe_d = 1'b0;
        cnt_d    = CNT_W'(HOLD_CYC);
      end
      HS_HOLD: begin // hold address and data past the ending edge
        if (cnt_q <= 1 && ack2_q) begin
          st_d = HS_IDLE;
          rv_d = !wr_q;
        end else if (cnt_q > 1) begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        st_d = HS_IDLE;
      end
    endcase
    sel_n_d = (st_d == HS_IDLE);
    wrs_n_d = !(strobe_d && wr_d && !style_d);
    rds_n_d = !(strobe_d && !wr_d && !style_d);
    dss_n_d = !(strobe_d && style_d);
    dir_d   = !wr_d;
    hoe_n_d = !((st_d != HS_IDLE) && wr_d);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q     <= HS_IDLE;
      cnt_q    <= '0;
      wr_q     <= 1'b0;
      style_q  <= 1'b0;
      a_q      <= '0;
      wd_q     <= '0;
      strobe_q <= 1'b0;
      rdy_q    <= 1'b0;
      rv_q     <= 1'b0;
      rd_q     <= '0;
      sel_n_q  <= 1'b1;
      wrs_n_q  <= 1'b1;
      rds_n_q  <= 1'b1;
      dss_n_q  <= 1'b1;
      dir_q    <= 1'b1;
      hoe_n_q  <= 1'b1;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      wr_q     <= wr_d;
      style_q  <= style_d;
      a_q      <= a_d;
      wd_q     <= wd_d;
      strobe_q <= strobe_d;
      rdy_q    <= rdy_d;
      rv_q     <= rv_d;
      rd_q     <= rd_d;
      sel_n_q  <= sel_n_d;
      wrs_n_q  <= wrs_n_d;
      rds_n_q  <= rds_n_d;
      dss_n_q  <= dss_n_d;
      dir_q    <= dir_d;
      hoe_n_q  <= hoe_n_d;
    end
  end

  assign pins.bus_layout_select   = 1'b0;
  assign pins.strobe_style_select = style_q;
  assign pins.host_reg_address    = a_q;
  assign pins.host_select_n       = sel_n_q;
  assign pins.host_write_strobe_n = wrs_n_q;
  assign pins.host_read_strobe_n  = rds_n_q;
  assign pins.host_data_strobe_n  = dss_n_q;
  assign pins.host_direction      = dir_q;
  assign pins.host_data_o         = wd_q;
  assign pins.host_data_oe_n      = hoe_n_q;
  assign req_ready = rdy_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rd_q;
endmodule // hps_host

// ==== rtl/hps_if.sv ====
// interface: host port pins between host and device
`timescale 1ns/1ps
interface hps_if;
  import hps_pkg::*;
  logic      bus_layout_select;
  logic      strobe_style_select;
  hps_addr_t host_reg_address;
  logic      host_select_n;
  logic      host_write_strobe_n;
  logic      host_read_strobe_n;
  logic      host_data_strobe_n;
  logic      host_direction;
  logic      port_acknowledge_n;
  hps_data_t host_data_o;
  logic      host_data_oe_n;
  hps_data_t dev_data_o;
  logic      dev_data_oe_n;
  hps_data_t data_bus;
  // resolved bus level; device wins while it drives
  assign data_bus = !dev_data_oe_n ? dev_data_o :
                    !host_data_oe_n ? host_data_o : 16'hFFFF;
  modport device (
    input  bus_layout_select, strobe_style_select, host_reg_address,
    input  host_select_n, host_write_strobe_n, host_read_strobe_n,
    input  host_data_strobe_n, host_direction, data_bus,
    output port_acknowledge_n, dev_data_o, dev_data_oe_n
  );
  modport host (
    output bus_layout_select, strobe_style_select, host_reg_address,
    output host_select_n, host_write_strobe_n, host_read_strobe_n,
    output host_data_strobe_n, host_direction, host_data_o,
    output host_data_oe_n,
    input  port_acknowledge_n, data_bus
  );
endinterface

// ==== rtl/hps_pkg.sv ====
// package: constants and types shared by both ends of the host port
package hps_pkg;
  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned NUM_REGS  = 8;
  // sync stages on the device side
  localparam int unsigned SYNC_LEN  = 2;
  // host timing figures in ns, and derived cycle counts at 50 MHz
  localparam int unsigned CLK_NS    = 20;
  localparam int unsigned SETUP_NS  = 8;
  localparam int unsigned PULSE_NS  = 30;
  localparam int unsigned HOLD_NS   = 3;
  localparam int unsigned SETUP_CYC =
    (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PULSE_CYC =
    (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HOLD_CYC  =
    (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W     = 4;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  typedef logic [ADDR_W-1:0] hps_addr_t;
  typedef logic [DATA_W-1:0] hps_data_t;
endpackage

// ==== tb/hps_properties.sv ====
// checker: pin timing relations of the host port
`timescale 1ns/1ps
module hps_properties
  import hps_pkg::*;
(
  input wire logic      clk,
  input wire logic      rst,
  input wire logic      bus_layout_select,
  input wire logic      strobe_style_select,
  input wire hps_addr_t host_reg_address,
  input wire logic      host_select_n,
  input wire logic      host_write_strobe_n,
  input wire logic      host_read_strobe_n,
  input wire logic      host_data_strobe_n,
  input wire logic      host_direction,
  input wire logic      port_acknowledge_n,
  input wire logic      host_data_oe_n,
  input wire logic      dev_data_oe_n
);
  logic wr_acc;
  logic rd_acc;
  logic acc;
  assign wr_acc = !host_select_n && (strobe_style_select ?
    (!host_data_strobe_n && !host_direction) : !host_write_strobe_n);
  assign rd_acc = !host_select_n && (strobe_style_select ?
    (!host_data_strobe_n && host_direction) : !host_read_strobe_n);
  assign acc = wr_acc || rd_acc;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_start;
    $rose(acc);
  endsequence
  sequence s_end;
    $fell(acc);
  endsequence
  a_ack_after_start: assert property (
    s_start |-> ##[2:3] !port_acknowledge_n) else $error("ack late");
  a_ack_holds: assert property (
    !port_acknowledge_n && acc |=> !port_acknowledge_n)
    else $error("ack dropped early");
  a_ack_release: assert property (
    s_end |-> ##[2:3] port_acknowledge_n) else $error("ack held");
  a_ack_cause: assert property (
    $fell(port_acknowledge_n) |-> $past(acc, 2)) else $error("ack no cause");
  a_oe_with_ack: assert property (
    !dev_data_oe_n |-> !port_acknowledge_n) else $error("oe without ack");
  a_oe_read_only: assert property (
    $fell(dev_data_oe_n) |-> $past(rd_acc, 2)) else $error("oe on write");
  a_oe_off_end: assert property (
    s_end |-> ##[2:3] dev_data_oe_n) else $error("bus not freed");
  a_addr_stable: assert property (
    acc && $past(acc) |-> $stable(host_reg_address)
    && $stable(host_direction)) else $error("addr moved");
  a_wdata_held: assert property (
    wr_acc |-> !host_data_oe_n) else $error("write data not driven");
  a_layout_sep: assert property (
    !bus_layout_select) else $error("layout not separate");
  a_style_pins: assert property (
    strobe_style_select ? (host_write_strobe_n && host_read_strobe_n)
    : host_data_strobe_n) else $error("wrong strobe style");
endmodule // hps_properties

// ==== tb/tb_top.sv ====
// testbench: host and device ends joined over the pin interface
`timescale 1ns/1ps
module tb_top;
  import hps_pkg::*;
  logic      clk;
  logic      rst;
  logic      style_sel;
  logic      req_valid;
  logic      req_write;
  hps_addr_t req_addr;
  hps_data_t req_wdata;
  logic      req_ready;
  logic      rsp_valid;
  hps_data_t rsp_rdata;
  hps_addr_t core_rd_addr;
  hps_data_t core_rd_data;
  logic      core_wr_pulse;
  hps_addr_t core_wr_addr;
  logic      layout_error;
  int        fails;
  int        n_tests;
  hps_if pins ();
  hps_host hps_host_inst (.clk(clk), .rst(rst), .pins(pins.host),
    .style_sel(style_sel), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  hps_device hps_device_inst (.clk(clk), .rst(rst), .pins(pins.device),
    .core_rd_data(core_rd_data), .core_rd_addr(core_rd_addr),
    .core_wr_pulse(core_wr_pulse), .core_wr_addr(core_wr_addr),
    .layout_error(layout_error));
  hps_properties chk_inst (.clk(clk), .rst(rst),
    .bus_layout_select(pins.bus_layout_select),
    .strobe_style_select(pins.strobe_style_select),
    .host_reg_address(pins.host_reg_address),
    .host_select_n(pins.host_select_n),
    .host_write_strobe_n(pins.host_write_strobe_n),
    .host_read_strobe_n(pins.host_read_strobe_n),
    .host_data_strobe_n(pins.host_data_strobe_n),
    .host_direction(pins.host_direction),
    .port_acknowledge_n(pins.port_acknowledge_n),
    .host_data_oe_n(pins.host_data_oe_n),
    .dev_data_oe_n(pins.dev_data_oe_n));
  always #10 clk = ~clk;
  task automatic check(input string what, input hps_data_t got,
                       input hps_data_t exp);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // bounded wait for a flag sampled high at a rising edge
  task automatic wait_high(ref logic sig);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sig !== 1'b1 && n < 60);
    if (sig !== 1'b1) begin
      fails++;
      $display("[FAIL] wait expected 1 seen timeout");
      finish_test();
    end
  endtask
  function automatic hps_data_t pat(input int i, input logic s);
    return hps_data_t'(16'hA5C3 ^ (i * 16'h1111)) ^ {s, 15'h0000};
  endfunction
  task automatic access(input logic s, input logic wr, input int a,
                        input hps_data_t d);
    style_sel <= s;
    req_write <= wr;
    req_addr <= hps_addr_t'(a);
    req_wdata <= d;
    req_valid <= 1'b1;
    wait_high(req_ready);
    req_valid <= 1'b0;
    if (wr) begin
      wait_high(core_wr_pulse);
      check("wr_addr", hps_data_t'(core_wr_addr), hps_data_t'(a));
    end else begin
      wait_high(rsp_valid);
      check("rd_data", rsp_rdata, d);
      check("oe_n", hps_data_t'(pins.dev_data_oe_n), 16'h0001);
    end
    core_rd_addr <= hps_addr_t'(a);
    repeat (2) @(posedge clk);
    check("core_data", core_rd_data, d);
  endtask
  // each register: old value, write, read back, in one strobe style
  task automatic t_style(input logic s);
    for (int i = 0; i < NUM_REGS; i++) begin
      access(s, 1'b0, i, s ? pat(i, 1'b0) : REG_RESET);
      access(s, 1'b1, i, pat(i, s));
      access(s, 1'b0, i, pat(i, s));
    end
    $display("test style %0d done", s);
  endtask
  // reset leaves the port idle in separate-bus layout
  task automatic t_reset();
    repeat (2) @(posedge clk);
    check("layout_error", hps_data_t'(layout_error), 16'h0000);
    check("ack_n", hps_data_t'(pins.port_acknowledge_n), 16'h0001);
    $display("test reset done");
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    style_sel = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 3'h0;
    req_wdata = 16'h0000;
    core_rd_addr = 3'h0;
    fails = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_style(1'b0);
    t_style(1'b1);
    finish_test();
  end
endmodule // tb_top
